/* bench/lsr_far.sv */
// Far-side model: persistent parameter store and the terminals' own sources.
`timescale 1ns/1ps
`default_nettype none
module lsr_far (
	output logic [79:0] nv_par_o,
	output logic [2:0] y_other_o,
	output logic [31:0] fm_other_o
);
	always_comb
	begin
		for (int k = 0; k < 5; k++) nv_par_o[k*16 +: 16] = 16'h0100 + 16'(k);
		y_other_o = 3'h5;
		fm_other_o = 32'h00aa_0055;
	end
endmodule
`default_nettype wire

/* bench/lsr_route_sva.sv */
// Checker for the logic step routing block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module lsr_route_sva #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [199:0] step_dig_i,
	input wire logic [79:0] route_src_sel_i,
	input wire logic [109:0] route_dest_sel_i,
	input wire logic [9:0] routed_dig_o,
	input wire logic [63:0] seq_func_o,
	input wire logic [7:0] ovr_grp_i,
	input wire logic [6:0] ovr_num_i,
	input wire logic ovr_en_i,
	input wire logic [W-1:0] ovr_val_i,
	input wire logic [W-1:0] ovr_out_o,
	input wire logic signed [W-1:0] dnc_pid_i,
	input wire logic [W-1:0] dnc_line_i,
	input wire logic [7:0] dnc_gain_i,
	input wire logic [W-1:0] dnc_fmax_i,
	input wire logic dnc_sel_i,
	input wire logic signed [W-1:0] dnc_out_o,
	input wire logic scan_tick_o
);
	logic dig_q;
	logic [W-1:0] dl_q, dg_q;
	// Expected values, taken at the edge where the design takes its inputs.
	always_ff @(posedge clk_i)
	begin
		dig_q <= step_dig_i[route_src_sel_i[7:0] - 8'h01];
		dl_q <= W'(longint'(dnc_pid_i) * longint'(dnc_line_i) / 20000);
		dg_q <= W'(longint'(dnc_pid_i) * longint'(dnc_gain_i) * longint'(dnc_fmax_i) / 2000000);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Tick sampled high marks the edge at which the design takes its inputs.
	sequence s_take(c);
		scan_tick_o && c;
	endsequence
	property p_gap;
		scan_tick_o |=> !scan_tick_o [*7];
	endproperty
	property p_hold;
		!$past(scan_tick_o) |-> $stable(routed_dig_o) && $stable(ovr_out_o);
	endproperty
	property p_off;
		s_take(route_src_sel_i[7:0] == 8'h00) |=> !routed_dig_o[0];
	endproperty
	property p_sel;
		s_take(route_src_sel_i[7:0] inside {[8'h01:8'hc8]}) |=> routed_dig_o[0] == dig_q;
	endproperty
	property p_seq;
		s_take(route_dest_sel_i[10:0] == 11'h000) |=> seq_func_o[0] || !routed_dig_o[0];
	endproperty
	property p_ovr;
		s_take(ovr_en_i && ovr_grp_i == 8'h27 && ovr_num_i inside {[7'h47:7'h4b]})
			|=> ovr_out_o == $past(ovr_val_i);
	endproperty
	property p_bad;
		s_take(ovr_grp_i != 8'h27) |=> ovr_out_o == '0;
	endproperty
	property p_dl;
		s_take(!dnc_sel_i || dnc_gain_i == 8'h00) |=> dnc_out_o == dl_q;
	endproperty
	property p_dg;
		s_take(dnc_sel_i && dnc_gain_i != 8'h00) |=> dnc_out_o == dg_q;
	endproperty
	a_gap: assert property (p_gap) else $error("scan tick too soon");
	a_hold: assert property (p_hold) else $error("output moved off scan");
	a_off: assert property (p_off) else $error("disabled output high");
	a_sel: assert property (p_sel) else $error("wrong routed source");
	a_seq: assert property (p_seq) else $error("sequence input missed");
	a_ovr: assert property (p_ovr) else $error("override not applied");
	a_bad: assert property (p_bad) else $error("bad target not zero");
	a_dl: assert property (p_dl) else $error("line speed form wrong");
	a_dg: assert property (p_dg) else $error("gain form wrong");
endmodule
bind lsr_route lsr_route_sva #(.W(W)) u_sva (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.step_dig_i(step_dig_i),
	.route_src_sel_i(route_src_sel_i),
	.route_dest_sel_i(route_dest_sel_i),
	.routed_dig_o(routed_dig_o),
	.seq_func_o(seq_func_o),
	.ovr_grp_i(ovr_grp_i),
	.ovr_num_i(ovr_num_i),
	.ovr_en_i(ovr_en_i),
	.ovr_val_i(ovr_val_i),
	.ovr_out_o(ovr_out_o),
	.dnc_pid_i(dnc_pid_i),
	.dnc_line_i(dnc_line_i),
	.dnc_gain_i(dnc_gain_i),
	.dnc_fmax_i(dnc_fmax_i),
	.dnc_sel_i(dnc_sel_i),
	.dnc_out_o(dnc_out_o),
	.scan_tick_o(scan_tick_o)
);
`default_nettype wire

/* bench/tb_lsr_route.sv */
// Self-checking bench for the logic step routing block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module tb_lsr_route;
	logic clk_i = 0, nrst_i = 0, ovr_en_i = 0, dnc_sel_i = 0, scan_tick_o;
	logic [199:0] step_dig_i = {25{8'ha5}};
	logic [3199:0] step_ana_i = '0;
	logic [31:0] step_in_sel_i = '0, fm_other_i;
	logic [79:0] route_src_sel_i = '0, nv_par_i, par_work_o;
	logic [109:0] route_dest_sel_i = {10{11'h064}};
	logic [29:0] y_func_i = '0;
	logic [19:0] fm_func_i = '0;
	logic [7:0] ovr_grp_i = '0, dnc_gain_i = '0;
	logic [6:0] ovr_num_i = '0;
	logic [15:0] ovr_val_i = '0, dnc_line_i = '0, dnc_fmax_i = '0, ovr_out_o;
	logic signed [15:0] dnc_pid_i = '0, dnc_out_o;
	logic [3:0] step_in_dig_o;
	logic [63:0] step_in_ana_o, seq_func_o;
	logic [9:0] routed_dig_o;
	logic [159:0] routed_ana_o;
	logic [255:0] ana_func_o;
	logic [15:0] ana_func_vld_o;
	logic [2:0] y_other_i, y_o;
	logic [31:0] fm_o;
	int err_count = 0, checks_done = 0, cyc = 0, i, s;
	lsr_route #(.SCAN_CYC(8), .YREF_CYC(40)) uut (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.step_dig_i(step_dig_i),
		.step_ana_i(step_ana_i),
		.step_in_sel_i(step_in_sel_i),
		.step_in_dig_o(step_in_dig_o),
		.step_in_ana_o(step_in_ana_o),
		.route_src_sel_i(route_src_sel_i),
		.route_dest_sel_i(route_dest_sel_i),
		.routed_dig_o(routed_dig_o),
		.routed_ana_o(routed_ana_o),
		.seq_func_o(seq_func_o),
		.ana_func_o(ana_func_o),
		.ana_func_vld_o(ana_func_vld_o),
		.y_func_i(y_func_i),
		.y_other_i(y_other_i),
		.y_o(y_o),
		.fm_func_i(fm_func_i),
		.fm_other_i(fm_other_i),
		.fm_o(fm_o),
		.ovr_grp_i(ovr_grp_i),
		.ovr_num_i(ovr_num_i),
		.ovr_en_i(ovr_en_i),
		.ovr_val_i(ovr_val_i),
		.nv_par_i(nv_par_i),
		.par_work_o(par_work_o),
		.ovr_out_o(ovr_out_o),
		.dnc_pid_i(dnc_pid_i),
		.dnc_line_i(dnc_line_i),
		.dnc_gain_i(dnc_gain_i),
		.dnc_fmax_i(dnc_fmax_i),
		.dnc_sel_i(dnc_sel_i),
		.dnc_out_o(dnc_out_o),
		.scan_tick_o(scan_tick_o)
	);
	lsr_far u_far (.nv_par_o(nv_par_i), .y_other_o(y_other_i), .fm_other_o(fm_other_i));
	// Free-running 200 MHz clock.
	initial forever #2.5 clk_i = ~clk_i;
	// Hang guard: a run far past the expected length counts as a failure.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			summarize;
		end
	end
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Waits for one scan update to land; the guard bounds the wait.
	task automatic upd;
		@(posedge clk_i iff scan_tick_o);
		repeat (2) @(posedge clk_i);
	endtask
	function automatic logic ed(int s);
		return s == 0 ? 1'b0 : step_dig_i[s-1];
	endfunction
	function automatic logic [15:0] ea(int s);
		return s == 0 ? 16'h0 : step_ana_i[(s-1)*16 +: 16];
	endfunction
	// Drives one dancer case and compares with the documented formulas.
	task automatic dnc(longint p, longint l, longint g, longint f, logic m);
		dnc_pid_i <= 16'(p);
		dnc_line_i <= 16'(l);
		dnc_gain_i <= 8'(g);
		dnc_fmax_i <= 16'(f);
		dnc_sel_i <= m;
		upd;
		`CHK(dnc_out_o, (m && g != 0) ? 16'(p * g * f / 2000000) : 16'(p * l / 20000))
	endtask
	// Main sequence.
	initial
	begin
		for (i = 0; i < 200; i++) step_ana_i[i*16 +: 16] <= 16'h1000 + 16'(i);
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(par_work_o, nv_par_i)
		$display("test powerup done");
		for (i = 0; i < 10; i++) route_src_sel_i[i*8 +: 8] <= (i == 9) ? 8'hc8 : 8'(i * 22);
		step_in_sel_i <= {8'hc8, 8'h00, 8'h07, 8'h01};
		route_dest_sel_i[32:0] <= {11'h200, 11'h000, 11'h064};
		y_func_i[9:0] <= 10'h0c9;
		fm_func_i[9:0] <= 10'h0c9;
		upd;
		for (i = 0; i < 10; i++)
		begin
			s = route_src_sel_i[i*8 +: 8];
			`CHK(routed_dig_o[i], ed(s))
			`CHK(routed_ana_o[i*16 +: 16], ea(s))
		end
		`CHK(step_in_dig_o, {ed(200), 1'b0, ed(7), ed(1)})
		`CHK(step_in_ana_o, {ea(200), 16'h0, ea(7), ea(1)})
		`CHK(seq_func_o, 64'(ed(22)))
		`CHK(ana_func_o[15:0], ea(44))
		`CHK(ana_func_vld_o, 16'h0001)
		`CHK(fm_o, {fm_other_i[31:16], ea(22)})
		repeat (45) @(posedge clk_i);
		`CHK(y_o, {y_other_i[2:1], ed(22)})
		$display("test routing done");
		// group code within 0 to 255
		ovr_grp_i <= 8'h27;
		// two-digit number within 0 to 99
		ovr_num_i <= 7'h48;
		ovr_val_i <= 16'h1234;
		ovr_en_i <= 1'b1;
		upd;
		`CHK(ovr_out_o, 16'h1234)
		`CHK(par_work_o, {nv_par_i[79:32], 16'h1234, nv_par_i[15:0]})
		// override halted before values are read out
		ovr_en_i <= 1'b0;
		upd;
		`CHK(ovr_out_o, nv_par_i[31:16])
		`CHK(par_work_o, nv_par_i)
		ovr_grp_i <= 8'h26;
		route_src_sel_i[7:0] <= 8'h06;
		route_dest_sel_i[10:0] <= 11'h000;
		step_in_sel_i[31:24] <= 8'hc9;
		upd;
		`CHK(ovr_out_o, 16'h0)
		`CHK(routed_dig_o[0], ed(6))
		`CHK(seq_func_o, 64'(ed(6) | ed(22)))
		`CHK(step_in_dig_o[3], 1'b0)
		`CHK(step_in_ana_o[63:48], 16'h0)
		ovr_grp_i <= 8'h27;
		ovr_num_i <= 7'h4c;
		upd;
		`CHK(ovr_out_o, 16'h0)
		ovr_num_i <= 7'h48;
		ovr_en_i <= 1'b1;
		upd;
		`CHK(par_work_o, {nv_par_i[79:32], 16'h1234, nv_par_i[15:0]})
		nrst_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(par_work_o, nv_par_i)
		$display("test override done");
		dnc(-4000, 300, 200, 500, 1'b1);
		dnc(-4000, 300, 0, 500, 1'b1);
		dnc(5000, 1000, 100, 500, 1'b0);
		$display("test dancer done");
		summarize;
	end
endmodule
`default_nettype wire

/* logic/lsr_params.svh */
// Constants for the logic step routing block: codes, reset values and timing.
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// Clock rate in MHz and the scan and terminal refresh periods in microseconds.
`define LSR_CLK_MHZ 200
`define LSR_SCAN_US 1000
`define LSR_YREF_US 5000

// Counts of sources, routed outputs and destinations.
`define LSR_NSTEP 200
`define LSR_NROUT 10
`define LSR_NSEQ 64
`define LSR_NANA 16

// Source select value that disables a routed output.
`define LSR_SRC_OFF 8'h00

// Destination select: first analog input function code, and the idle code.
`define LSR_DEST_ANA_BASE 11'h200
`define LSR_DEST_RST 11'h064

// Terminal function code of the first routed output on digital and analog terminals.
`define LSR_TERM_CLO_BASE 10'h0c8

// Overridable parameter group and lowest number inside that group.
`define LSR_OVR_GRP 8'h27
`define LSR_OVR_NUM_LO 7'h47

// PID output code meaning 100 percent, and the percent scale of the gain ratio.
`define LSR_PCT_FULL 32'd20000
`define LSR_PCT_UNIT 32'd100

`endif

/* logic/lsr_pkg.sv */
// Types shared by the logic step routing block.
`default_nettype none
package lsr_pkg;
	// Kind of destination that a routed output is tied to.
	typedef enum logic [1:0] {
		DEST_NONE,
		DEST_SEQ,
		DEST_ANA
	} lsr_dest_e;
endpackage
`default_nettype wire

/* logic/lsr_route.sv */
// Logic step back end: parameter override, dancer correction and output routing.
// Notes on behaviour
// - Override input true substitutes input one value.
// - Substitute lives in working copy, not store.
// - Overrides vanish when power goes away.
// - Power-up reloads working values from store.
// - Unknown target parameter gives zero output.
// - Dancer correction has two scaling modes.
// - Mode off: PID times line speed.
// - Mode on: PID times gain times fmax.
// - Zero gain forces line speed formula.
// - Each step result is numbered source.
// - Ten routed outputs, each with source select.
// - Step inputs pick any step directly.
// - Destination select may pick analog function.
// - Digital terminal shows selected routed output.
// - Analog terminal shows selected routed output.
// - Digital terminals refresh every 5 ms.
// - Source zero disables; n selects step n.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_params.svh"

module lsr_route #(
	parameter int NSTEP = `LSR_NSTEP,
	parameter int NROUT = `LSR_NROUT,
	parameter int NSEQ = `LSR_NSEQ,
	parameter int NANA = `LSR_NANA,
	parameter int NIN = 4,
	parameter int NY = 3,
	parameter int NFM = 2,
	parameter int NPAR = 5,
	parameter int W = 16,
	parameter int SCAN_CYC = `LSR_SCAN_US * `LSR_CLK_MHZ,
	parameter int YREF_CYC = `LSR_YREF_US * `LSR_CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [NSTEP-1:0] step_dig_i,
	input wire logic [NSTEP*W-1:0] step_ana_i,
	input wire logic [NIN*8-1:0] step_in_sel_i,
	output logic [NIN-1:0] step_in_dig_o,
	output logic [NIN*W-1:0] step_in_ana_o,
	input wire logic [NROUT*8-1:0] route_src_sel_i,
	input wire logic [NROUT*11-1:0] route_dest_sel_i,
	output logic [NROUT-1:0] routed_dig_o,
	output logic [NROUT*W-1:0] routed_ana_o,
	output logic [NSEQ-1:0] seq_func_o,
	output logic [NANA*W-1:0] ana_func_o,
	output logic [NANA-1:0] ana_func_vld_o,
	input wire logic [NY*10-1:0] y_func_i,
	input wire logic [NY-1:0] y_other_i,
	output logic [NY-1:0] y_o,
	input wire logic [NFM*10-1:0] fm_func_i,
	input wire logic [NFM*W-1:0] fm_other_i,
	output logic [NFM*W-1:0] fm_o,
	input wire logic [7:0] ovr_grp_i,
	input wire logic [6:0] ovr_num_i,
	input wire logic ovr_en_i,
	input wire logic [W-1:0] ovr_val_i,
	input wire logic [NPAR*W-1:0] nv_par_i,
	output logic [NPAR*W-1:0] par_work_o,
	output logic [W-1:0] ovr_out_o,
	input wire logic signed [W-1:0] dnc_pid_i,
	input wire logic [W-1:0] dnc_line_i,
	input wire logic [7:0] dnc_gain_i,
	input wire logic [W-1:0] dnc_fmax_i,
	input wire logic dnc_sel_i,
	output logic signed [W-1:0] dnc_out_o,
	output logic scan_tick_o
);

	// Refuse shapes that the 8-bit source selects and 11-bit destination codes cannot reach.
	if (NSTEP < 1 || NSTEP > 255 || NROUT < 1 || NROUT > 64 || W < 2 || W > 24
		|| SCAN_CYC < 1 || YREF_CYC < 1 || NPAR < 1 || NPAR > 28
		|| NSEQ < 1 || NSEQ > 512 || NANA < 1 || NANA > 1536 || NIN < 1 || NY < 1 || NFM < 1)
	begin : g_bad_cfg
		$error("lsr_route: unsupported parameter values");
	end

	// The whole state of the block in one record.
	typedef struct packed {
		logic [31:0] scan_cnt;
		logic [31:0] yref_cnt;
		logic tick;
		logic loaded;
		logic [NPAR-1:0][W-1:0] work;
		logic [NPAR-1:0] ovr_act;
		logic [W-1:0] ovr_val;
		logic [W-1:0] ovr_out;
		logic signed [W-1:0] dnc;
		logic [NIN-1:0] in_dig;
		logic [NIN-1:0][W-1:0] in_ana;
		logic [NROUT-1:0] rdig;
		logic [NROUT-1:0][W-1:0] rana;
		logic [NSEQ-1:0] seq;
		logic [NANA-1:0][W-1:0] ana;
		logic [NANA-1:0] ana_vld;
		logic [NY-1:0] y;
		logic [NFM-1:0][W-1:0] fm;
	} lsr_state_s;

	lsr_state_s st_ff;
	lsr_state_s nxt_st;

	// Classify a destination code as a sequence input, an analog function or nothing.
	function automatic lsr_pkg::lsr_dest_e dest_kind(input logic [10:0] code);
		lsr_pkg::lsr_dest_e k;
		k = lsr_pkg::DEST_NONE;
		if (code < 11'(NSEQ))
		begin
			k = lsr_pkg::DEST_SEQ;
		end
		else if (code >= `LSR_DEST_ANA_BASE && code < `LSR_DEST_ANA_BASE + 11'(NANA))
		begin
			k = lsr_pkg::DEST_ANA;
		end
		return k;
	endfunction

	// Next-state logic: everything moves on the scan tick except the counters, the power-up reload and the digital terminal refresh.
	always_comb
	begin
		logic [7:0] sel;
		logic [10:0] dsel;
		logic [9:0] tf;
		int idx;
		int hit;
		logic signed [63:0] prod;
		nxt_st = st_ff;
		sel = 8'h00;
		dsel = 11'h000;
		tf = 10'h000;
		idx = 0;
		hit = -1;
		prod = 64'sh0;

		// The scan divider gives a one-cycle enable per scan period.
		nxt_st.tick = 1'b0;
		if (st_ff.scan_cnt >= 32'(SCAN_CYC - 1))
		begin
			nxt_st.scan_cnt = 32'h0;
			nxt_st.tick = 1'b1;
		end
		else
		begin
			nxt_st.scan_cnt = st_ff.scan_cnt + 32'h1;
		end

		// The first cycle after reset copies the persistent store into working memory.
		// power-up reload
		if (!st_ff.loaded)
		begin
			nxt_st.loaded = 1'b1;
			for (int p = 0; p < NPAR; p++)
			begin
				nxt_st.work[p] = nv_par_i[p*W +: W];
			end
		end

		if (st_ff.tick)
		begin
			if (ovr_grp_i == `LSR_OVR_GRP && ovr_num_i >= `LSR_OVR_NUM_LO
				&& ovr_num_i < `LSR_OVR_NUM_LO + 7'(NPAR))
			begin
				hit = int'(ovr_num_i - `LSR_OVR_NUM_LO);
			end
			nxt_st.ovr_act = '0;
			nxt_st.ovr_val = ovr_val_i;
			nxt_st.ovr_out = '0;
			if (hit >= 0)
			begin
				nxt_st.ovr_act[hit] = ovr_en_i;
				nxt_st.ovr_out = ovr_en_i ? ovr_val_i : st_ff.work[hit];
			end

			if (dnc_sel_i && dnc_gain_i != 8'h00)
			begin
				prod = 64'(dnc_pid_i) * $signed({1'b0, dnc_gain_i})
					* $signed({1'b0, dnc_fmax_i});
				prod = prod / $signed(64'(`LSR_PCT_FULL * `LSR_PCT_UNIT));
			end
			else
			begin
				prod = 64'(dnc_pid_i) * $signed({1'b0, dnc_line_i});
				prod = prod / $signed(64'(`LSR_PCT_FULL));
			end
			nxt_st.dnc = prod[W-1:0];

			for (int i = 0; i < NIN; i++)
			begin
				sel = step_in_sel_i[i*8 +: 8];
				nxt_st.in_dig[i] = 1'b0;
				nxt_st.in_ana[i] = '0;
				if (sel != `LSR_SRC_OFF && int'(sel) <= NSTEP)
				begin
					idx = int'(sel) - 1;
					nxt_st.in_dig[i] = step_dig_i[idx];
					nxt_st.in_ana[i] = step_ana_i[idx*W +: W];
				end
			end

			// Routed outputs and their destinations are rebuilt from scratch each scan.
			nxt_st.seq = '0;
			nxt_st.ana = '0;
			nxt_st.ana_vld = '0;
			for (int r = 0; r < NROUT; r++)
			begin
				sel = route_src_sel_i[r*8 +: 8];
				dsel = route_dest_sel_i[r*11 +: 11];
				nxt_st.rdig[r] = 1'b0;
				nxt_st.rana[r] = '0;
				if (sel != `LSR_SRC_OFF && int'(sel) <= NSTEP)
				begin
					idx = int'(sel) - 1;
					nxt_st.rdig[r] = step_dig_i[idx];
					nxt_st.rana[r] = step_ana_i[idx*W +: W];
				end
				case (dest_kind(dsel))
					lsr_pkg::DEST_SEQ:
					begin
						idx = int'(dsel);
						nxt_st.seq[idx] = nxt_st.seq[idx] | nxt_st.rdig[r];
					end
					lsr_pkg::DEST_ANA:
					begin
						idx = int'(dsel - `LSR_DEST_ANA_BASE);
						nxt_st.ana[idx] = nxt_st.rana[r];
						nxt_st.ana_vld[idx] = 1'b1;
					end
					default:
					begin
						nxt_st.seq = nxt_st.seq;
					end
				endcase
			end

			for (int f = 0; f < NFM; f++)
			begin
				tf = fm_func_i[f*10 +: 10];
				nxt_st.fm[f] = fm_other_i[f*W +: W];
				if (tf >= `LSR_TERM_CLO_BASE && tf < `LSR_TERM_CLO_BASE + 10'(NROUT))
				begin
					nxt_st.fm[f] = nxt_st.rana[int'(tf - `LSR_TERM_CLO_BASE)];
				end
			end
		end

		// The digital terminal refresh runs on its own slower divider.
		if (st_ff.yref_cnt >= 32'(YREF_CYC - 1))
		begin
			nxt_st.yref_cnt = 32'h0;
			for (int y = 0; y < NY; y++)
			begin
				tf = y_func_i[y*10 +: 10];
				nxt_st.y[y] = y_other_i[y];
				if (tf >= `LSR_TERM_CLO_BASE && tf < `LSR_TERM_CLO_BASE + 10'(NROUT))
				begin
					nxt_st.y[y] = st_ff.rdig[int'(tf - `LSR_TERM_CLO_BASE)];
				end
			end
		end
		else
		begin
			nxt_st.yref_cnt = st_ff.yref_cnt + 32'h1;
		end
	end

	// State register; reset stands for power loss, so all overrides are dropped.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			st_ff <= '0;
			for (int r = 0; r < NROUT; r++)
			begin
				st_ff.rdig[r] <= 1'b0;
			end
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Parameter consumers see the override in place of the working value.
	always_comb
	begin
		for (int p = 0; p < NPAR; p++)
		begin
			par_work_o[p*W +: W] = st_ff.ovr_act[p] ? st_ff.ovr_val : st_ff.work[p];
		end
	end

	// Outputs straight from the state record.
	assign step_in_dig_o = st_ff.in_dig;
	assign step_in_ana_o = st_ff.in_ana;
	assign routed_dig_o = st_ff.rdig;
	assign routed_ana_o = st_ff.rana;
	assign seq_func_o = st_ff.seq;
	assign ana_func_o = st_ff.ana;
	assign ana_func_vld_o = st_ff.ana_vld;
	assign y_o = st_ff.y;
	assign fm_o = st_ff.fm;
	assign ovr_out_o = st_ff.ovr_out;
	assign dnc_out_o = st_ff.dnc;
	assign scan_tick_o = st_ff.tick;

endmodule
`default_nettype wire
